// ---- sdcd_pkg.sv ----
// Shared constants and types of the synchronous DRAM command decoder.
// Assumes a single clock domain driven by the memory controller's clock.
package sdcd_pkg;

	// ----------------------------------------
	// Command encodings {cs_n, ras_n, cas_n, we_n}
	// ----------------------------------------
	localparam logic [3:0] SDCD_ENC_ACTIVATE  = 4'h3;
	localparam logic [3:0] SDCD_ENC_READ      = 4'h5;
	localparam logic [3:0] SDCD_ENC_WRITE     = 4'h4;
	localparam logic [3:0] SDCD_ENC_BSTOP     = 4'h6;
	localparam logic [3:0] SDCD_ENC_PRECHARGE = 4'h2;
	localparam logic [3:0] SDCD_ENC_MODE_SET  = 4'h0;
	localparam logic [3:0] SDCD_ENC_REFRESH   = 4'h1;
	localparam logic [3:0] SDCD_ENC_NOP       = 4'h7;

	// ----------------------------------------
	// Field positions and widths
	// ----------------------------------------
	localparam int SDCD_AP_BIT     = 10;
	localparam int SDCD_ADDR_W     = 13;
	localparam int SDCD_BANK_W     = 2;
	localparam int SDCD_NBANK      = 4;
	localparam int SDCD_DQM_W      = 2;
	localparam int SDCD_BURST_CNT_W = 9;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic SDCD_CKE_RST = 1'b1;

	// ----------------------------------------
	// Decoded command, one-hot
	// ----------------------------------------
	typedef enum logic [10:0]
	{
		SDCD_CMD_NONE     = 11'h001,
		SDCD_CMD_ACTIVATE = 11'h002,
		SDCD_CMD_READ     = 11'h004,
		SDCD_CMD_WRITE    = 11'h008,
		SDCD_CMD_PRE_ONE  = 11'h010,
		SDCD_CMD_PRE_ALL  = 11'h020,
		SDCD_CMD_MODE_SET = 11'h040,
		SDCD_CMD_BSTOP    = 11'h080,
		SDCD_CMD_REFRESH  = 11'h100,
		SDCD_CMD_SREF_IN  = 11'h200,
		SDCD_CMD_NOP      = 11'h400
	} sdcd_cmd_t;

	// ----------------------------------------
	// Device power state, one-hot
	// ----------------------------------------
	typedef enum logic [3:0]
	{
		SDCD_ST_NORMAL  = 4'h1,
		SDCD_ST_SUSPEND = 4'h2,
		SDCD_ST_PDOWN   = 4'h4,
		SDCD_ST_SREF    = 4'h8
	} sdcd_state_t;

endpackage

// ---- sdcd_cmd_table.sv ----
// Pure truth-table decoder: one cycle of command pins to a one-hot command.
// Assumes pins are synchronous to clk_sys; a low registered clock enable (cke_prev) yields no command.
`timescale 1ns/1ps

module sdcd_cmd_table
	import sdcd_pkg::*;
(
	input  wire logic       cs_n,
	input  wire logic       ras_n,
	input  wire logic       cas_n,
	input  wire logic       we_n,
	input  wire logic       cke_prev,
	input  wire logic       cke_now,
	input  wire logic       a10,
	output sdcd_cmd_t       cmd
);

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	always_comb
	begin
		cmd = SDCD_CMD_NONE;
		if (cke_prev)
		begin
			if (cs_n)
				cmd = SDCD_CMD_NOP;
			else
			begin
				case ({1'b0, ras_n, cas_n, we_n})
					SDCD_ENC_ACTIVATE:  cmd = SDCD_CMD_ACTIVATE;
					SDCD_ENC_READ:      cmd = SDCD_CMD_READ;
					SDCD_ENC_WRITE:     cmd = SDCD_CMD_WRITE;
					SDCD_ENC_BSTOP:     cmd = SDCD_CMD_BSTOP;
					SDCD_ENC_PRECHARGE: cmd = a10 ? SDCD_CMD_PRE_ALL : SDCD_CMD_PRE_ONE;
					SDCD_ENC_MODE_SET:  cmd = SDCD_CMD_MODE_SET;
					SDCD_ENC_REFRESH:   cmd = cke_now ? SDCD_CMD_REFRESH : SDCD_CMD_SREF_IN;
					SDCD_ENC_NOP:       cmd = SDCD_CMD_NOP;
					default:            cmd = SDCD_CMD_NONE;
				endcase
			end
		end
	end

endmodule

// ---- sdcd_top.sv ----
// Command decoding and clock-enable control of a synchronous DRAM.
// Assumes a controller drives all pins synchronously to clk_sys; the storage array is outside.
`timescale 1ns/1ps

module sdcd_top
	import sdcd_pkg::*;
#(
	parameter int BURST_LEN = 8
)
(
	input  wire logic                        clk_sys,
	input  wire logic                        sys_rst,
	input  wire logic                        cke,
	input  wire logic                        cs_n,
	input  wire logic                        ras_n,
	input  wire logic                        cas_n,
	input  wire logic                        we_n,
	input  wire logic [SDCD_BANK_W-1:0]      bank_select,
	input  wire logic [SDCD_ADDR_W-1:0]      addr,
	input  wire logic [SDCD_DQM_W-1:0]       dqm,
	output logic                             internal_clk_en,
	output logic [SDCD_NBANK-1:0]            bank_active,
	output logic                             burst_busy,
	output logic                             burst_is_write,
	output logic                             auto_precharge,
	output logic                             suspended,
	output logic                             powered_down,
	output logic                             self_refresh,
	output logic                             mode_set_pulse,
	output logic                             refresh_pulse,
	output logic [SDCD_ADDR_W-1:0]           mode_value,
	output logic [SDCD_DQM_W-1:0]            write_lane_en,
	output logic [SDCD_DQM_W-1:0]            read_drive_en
);

	// ----------------------------------------
	// Sampling and decode
	// ----------------------------------------
	logic             cke_prev;
	sdcd_cmd_t        cmd;
	sdcd_state_t      state;
	sdcd_state_t      next_state;
	logic [SDCD_BURST_CNT_W-1:0] burst_left;
	logic             any_active;
	logic             idle_cmd;
	logic             accept;

	// Clock enable is sampled every edge, even while suspended, so exits are seen.
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			cke_prev <= SDCD_CKE_RST;
		else
			cke_prev <= cke;
	end

	sdcd_cmd_table u_table
	(
		.cs_n     (cs_n),
		.ras_n    (ras_n),
		.cas_n    (cas_n),
		.we_n     (we_n),
		.cke_prev (cke_prev),
		.cke_now  (cke),
		.a10      (addr[SDCD_AP_BIT]),
		.cmd      (cmd)
	);

	assign any_active = |bank_active;
	assign idle_cmd   = (cmd == SDCD_CMD_NOP);
	// Commands take effect only in normal state with the clock running.
	assign accept     = (state == SDCD_ST_NORMAL) && cke_prev;

	// ----------------------------------------
	// Power state machine
	// ----------------------------------------
	always_comb
	begin
		next_state = state;
		case (state)
			SDCD_ST_NORMAL:
			begin
				if (cke_prev && !cke)
				begin
					if (cmd == SDCD_CMD_SREF_IN && !any_active)
						next_state = SDCD_ST_SREF;
					else if (burst_busy || any_active)
						next_state = SDCD_ST_SUSPEND;
					else if (idle_cmd)
						next_state = SDCD_ST_PDOWN;
				end
			end
			SDCD_ST_SUSPEND:
				if (cke)
					next_state = SDCD_ST_NORMAL;
			SDCD_ST_PDOWN:
				if (cke && (cs_n || (ras_n && cas_n)))
					next_state = SDCD_ST_NORMAL;
			SDCD_ST_SREF:
				if (cke)
					next_state = SDCD_ST_NORMAL;
			default:
				next_state = SDCD_ST_NORMAL;
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			state <= SDCD_ST_NORMAL;
		else
			state <= next_state;
	end

	// The freeze follows the registered low clock enable, one clock after sampling.
	assign internal_clk_en = (state == SDCD_ST_NORMAL) && cke_prev;
	assign suspended       = (state == SDCD_ST_SUSPEND);
	assign powered_down    = (state == SDCD_ST_PDOWN);
	assign self_refresh    = (state == SDCD_ST_SREF);

	// ----------------------------------------
	// Bank state
	// ----------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			bank_active <= '0;
		else if (accept)
		begin
			if (cmd == SDCD_CMD_ACTIVATE)
				bank_active[bank_select] <= 1'b1;
			else if (cmd == SDCD_CMD_PRE_ONE)
				bank_active[bank_select] <= 1'b0;
			else if (cmd == SDCD_CMD_PRE_ALL)
				bank_active <= '0;
			else if (burst_busy && auto_precharge && burst_left == 1)
				bank_active <= '0;
		end
	end

	// ----------------------------------------
	// Burst tracking
	// ----------------------------------------
	// A fixed burst length keeps the tracker small; mode-set lengths are not decoded.
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			burst_left     <= '0;
			burst_busy     <= 1'b0;
			burst_is_write <= 1'b0;
			auto_precharge <= 1'b0;
		end
		else if (accept)
		begin
			if (cmd == SDCD_CMD_READ || cmd == SDCD_CMD_WRITE)
			begin
				burst_left     <= SDCD_BURST_CNT_W'(BURST_LEN);
				burst_busy     <= 1'b1;
				burst_is_write <= (cmd == SDCD_CMD_WRITE);
				auto_precharge <= addr[SDCD_AP_BIT];
			end
			else if (cmd == SDCD_CMD_BSTOP || cmd == SDCD_CMD_PRE_ALL)
			begin
				burst_left <= '0;
				burst_busy <= 1'b0;
			end
			else if (burst_busy)
			begin
				burst_left <= burst_left - 1'b1;
				burst_busy <= (burst_left != 1);
			end
		end
	end

	// ----------------------------------------
	// Mode set and refresh
	// ----------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			mode_value     <= '0;
			mode_set_pulse <= 1'b0;
			refresh_pulse  <= 1'b0;
		end
		else
		begin
			mode_set_pulse <= accept && cmd == SDCD_CMD_MODE_SET && !any_active;
			refresh_pulse  <= accept && cmd == SDCD_CMD_REFRESH && !any_active;
			if (accept && cmd == SDCD_CMD_MODE_SET && !any_active)
				mode_value <= addr;
		end
	end

	// ----------------------------------------
	// Byte masking
	// ----------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			write_lane_en <= '0;
			read_drive_en <= '0;
		end
		else
		begin
			write_lane_en <= (any_active && burst_busy && burst_is_write) ? ~dqm : '0;
			read_drive_en <= (any_active && burst_busy && !burst_is_write) ? ~dqm : '0;
		end
	end

endmodule

// ---- sdcd_ctrl_model.sv ----
// Memory controller model that drives the decoder's command pins.
// Assumes the bench calls cmd once per cycle from a single process.
`timescale 1ns/1ps

module sdcd_ctrl_model
	import sdcd_pkg::*;
(
	input  wire logic                   clk_sys,
	output logic                        cke,
	output logic                        cs_n,
	output logic                        ras_n,
	output logic                        cas_n,
	output logic                        we_n,
	output logic [SDCD_BANK_W-1:0]      bank_select,
	output logic [SDCD_ADDR_W-1:0]      addr,
	output logic [SDCD_DQM_W-1:0]       dqm
);
	initial {cke, cs_n, ras_n, cas_n, we_n, bank_select, addr, dqm} = {1'b1, SDCD_ENC_NOP, 17'h0_0000};

	// Pins change 1 ns after an edge and hold for the whole cycle.
	task automatic cmd(input logic k, input logic [3:0] e, input logic [1:0] b, input logic [12:0] a);
		logic [15:0] noise;
		noise = 16'($urandom);
		@(posedge clk_sys);
		#1;
		cke = k;
		cs_n = e[3];
		bank_select = b;
		dqm = 2'($urandom);
		// Deselected pins carry noise, since the decoder must not look at them.
		{ras_n, cas_n, we_n, addr} = e[3] ? noise : {e[2:0], a};
	endtask
endmodule

// ---- sdcd_top_checker.sv ----
// Port assertions of the command decoder.
// Assumes one clock domain; bound to every decoder instance.
`timescale 1ns/1ps

module sdcd_top_checker
	import sdcd_pkg::*;
(
	input wire logic                   clk_sys,
	input wire logic                   sys_rst,
	input wire logic                   cke,
	input wire logic                   cs_n,
	input wire logic                   ras_n,
	input wire logic                   cas_n,
	input wire logic                   we_n,
	input wire logic [SDCD_BANK_W-1:0] bank_select,
	input wire logic [SDCD_DQM_W-1:0]  dqm,
	input wire logic                   internal_clk_en,
	input wire logic [SDCD_NBANK-1:0]  bank_active,
	input wire logic                   burst_busy,
	input wire logic                   burst_is_write,
	input wire logic                   suspended,
	input wire logic                   powered_down,
	input wire logic                   self_refresh,
	input wire logic                   mode_set_pulse,
	input wire logic                   refresh_pulse,
	input wire logic [SDCD_DQM_W-1:0]  read_drive_en
);
	logic [3:0] pins;
	logic       take;
	logic       idle;
	assign pins = {cs_n, ras_n, cas_n, we_n};
	assign take = internal_clk_en && cke;
	assign idle = cs_n || pins == SDCD_ENC_NOP;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	act_opens_bank_a: assert property (take && pins == SDCD_ENC_ACTIVATE |=> bank_active[$past(bank_select)])
		else $error("activate left bank closed");
	nop_keeps_banks_a: assert property (take && idle && !burst_busy |=> $stable(bank_active))
		else $error("idle cycle changed banks");
	suspend_entry_a: assert property (internal_clk_en && !cke && idle && bank_active != 4'h0 |=> suspended)
		else $error("no clock suspend");
	suspend_freeze_a: assert property (suspended |-> !internal_clk_en ##1 ($stable(bank_active) && $stable(burst_busy)))
		else $error("state moved in suspend");
	suspend_exit_a: assert property (suspended && cke |=> !suspended)
		else $error("suspend not left");
	pdown_entry_a: assert property (internal_clk_en && !cke && idle && bank_active == 4'h0 && !burst_busy |=> powered_down)
		else $error("no power down");
	sref_entry_a: assert property (internal_clk_en && !cke && pins == SDCD_ENC_REFRESH && bank_active == 4'h0 |=> self_refresh)
		else $error("no self refresh");
	mode_set_a: assert property (take && pins == SDCD_ENC_MODE_SET && bank_active == 4'h0 && !burst_busy |=> mode_set_pulse)
		else $error("mode set pulse missing");
	refresh_cmd_a: assert property (take && pins == SDCD_ENC_REFRESH && bank_active == 4'h0 |=> refresh_pulse)
		else $error("refresh pulse missing");
	read_mask_a: assert property (burst_busy && !burst_is_write && bank_active != 4'h0 |=> read_drive_en == ~$past(dqm))
		else $error("read drive mask wrong");
endmodule

bind sdcd_top sdcd_top_checker sdcd_top_checker_i (.*);

// ---- tb.sv ----
// Self-checking bench of the command decoder with a controller model.
// Assumes the decoder and its checker are compiled alongside.
`timescale 1ns/1ps

module tb;
	import sdcd_pkg::*;
	localparam int BL = 4;
	logic        clk_sys = 0, sys_rst = 1, cke, cs_n, ras_n, cas_n, we_n;
	logic        internal_clk_en, burst_busy, suspended, powered_down, self_refresh, refresh_pulse;
	logic        burst_is_write, auto_precharge;
	logic [1:0]  bank_select, dqm, write_lane_en, read_drive_en, b, d;
	logic [3:0]  bank_active;
	logic [12:0] addr, mode_value, a;
	int unsigned mismatches = 0, n_checks = 0, cyc = 0, n;

	sdcd_top #(.BURST_LEN(BL)) sdcd_top_i (.*, .mode_set_pulse());
	sdcd_ctrl_model sdcd_ctrl_model_i (.*);

	always #20 clk_sys = ~clk_sys;

	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask

	function automatic logic [15:0] bank_bit(input logic [1:0] bk);
		return 16'h0001 << bk;
	endfunction

	task automatic c(input logic k, input logic [3:0] e, input logic [1:0] bs = 0, input logic [12:0] ad = 0);
		sdcd_ctrl_model_i.cmd(k, e, bs, ad);
	endtask

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// The whole run needs some 290 cycles, so the ceiling leaves ample room.
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			mismatches++;
			print_verdict;
		end
	end

	initial
	begin
		void'($urandom(32'hdba8_fe9e));
		repeat (8) @(posedge clk_sys);
		#1 sys_rst = 0;
		chk("clk_en", 1, internal_clk_en);
		repeat (4)
		begin
			b = 2'($urandom);
			c(1, SDCD_ENC_ACTIVATE, b);
			repeat (6) c(1, 4'hF);
			chk("bank_active", bank_bit(b), bank_active);
			c(1, SDCD_ENC_READ, b);
			n = 0;
			repeat (12)
			begin
				c(1, SDCD_ENC_NOP);
				n += burst_busy;
			end
			chk("burst_len", BL, n);
			$display("activate and burst done");
			c(1, SDCD_ENC_READ, b);
			c(0, SDCD_ENC_NOP);
			repeat (3) c(0, SDCD_ENC_PRECHARGE, 0, 13'h0400);
			chk("suspended", 1, suspended);
			chk("bank_kept", bank_bit(b), bank_active);
			repeat (3) c(1, SDCD_ENC_NOP);
			chk("resumed", 0, suspended);
			repeat (8) c(1, SDCD_ENC_NOP);
			c(1, SDCD_ENC_WRITE, b);
			c(1, SDCD_ENC_NOP);
			d = dqm;
			c(1, SDCD_ENC_NOP);
			chk("lane_en", {14'h0, ~d}, write_lane_en);
			chk("is_write", 1, burst_is_write);
			c(1, SDCD_ENC_READ, b);
			c(1, SDCD_ENC_BSTOP);
			d = dqm;
			c(1, SDCD_ENC_NOP);
			chk("burst_stop", 0, burst_busy);
			chk("is_read", 0, burst_is_write);
			chk("read_en", {14'h0, ~d}, read_drive_en);
			$display("suspend and write done");
			c(1, SDCD_ENC_ACTIVATE, b + 2'd1);
			c(1, SDCD_ENC_PRECHARGE, b, 13'h0000);
			c(1, SDCD_ENC_NOP);
			chk("pre_one", bank_bit(b + 2'd1), bank_active);
			c(1, SDCD_ENC_PRECHARGE, 2'($urandom), 13'($urandom) | 13'h0400);
			a = 13'($urandom);
			c(1, SDCD_ENC_MODE_SET, 0, a);
			chk("pre_all", 0, bank_active);
			c(1, SDCD_ENC_REFRESH);
			chk("mode_value", a, mode_value);
			c(1, SDCD_ENC_NOP);
			chk("refresh", 1, refresh_pulse);
			c(1, SDCD_ENC_ACTIVATE, b);
			c(1, SDCD_ENC_WRITE, b, 13'h0400);
			repeat (BL) c(1, SDCD_ENC_NOP);
			chk("auto_pre", 1, auto_precharge);
			chk("ap_open", bank_bit(b), bank_active);
			c(1, SDCD_ENC_NOP);
			chk("ap_closed", 0, bank_active);
			$display("precharge and mode done");
			c(0, 4'hF);
			repeat (3) c(0, SDCD_ENC_ACTIVATE, b);
			chk("pdown", 1, powered_down);
			chk("pd_banks", 0, bank_active);
			c(1, 4'hF);
			repeat (2) c(1, SDCD_ENC_NOP);
			chk("pd_exit", 0, powered_down);
			c(0, SDCD_ENC_REFRESH);
			repeat (3) c(0, 4'hF);
			chk("sref", 1, self_refresh);
			c(1, 4'hF);
			repeat (2) c(1, SDCD_ENC_NOP);
			chk("sref_exit", 0, self_refresh);
			$display("power modes done");
		end
		print_verdict;
	end
endmodule
